// ==== hw/owm_master_ctrl.sv ====
/*
 * single-wire bus master: tick divider, control/status word, bus reset and
 * presence sequence, manual line control, reset-complete interrupt, APB slave.
 * assumes: APB master on mclk; open-drain wire with external pull-up;
 * software sets the divisor for a tick of about 1 us.
 */
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "owm_defines.svh"

// Contract
// (RULE1) divisor zero stops the timing clock; no bus activity is timed
// (RULE2) divisor 1..255 divides the bus clock by that value
// (RULE3) presence flag is one when a slave answered the last bus reset
// (RULE4) line level bit reads the live wire level, no reset value
// (RULE5) with manual control on, pull-low bit one drives wire low, zero releases
// (RULE6) search assist bit selects accelerated ROM search mode
// (RULE7) writing one to reset request starts reset and presence sequence
// (RULE8) hardware clears reset request when the sequence finishes
// (RULE9) overdrive revision bit is read-only and reads zero
// (RULE10) pull-low bit acts only while manual control enable is set
// (RULE11) reset complete flag set at sequence end; write one clears it
// (RULE12) presence flag holds until the next reset sequence completes
module owm_master_ctrl (
    // clock, reset, enable
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic        ce_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // interrupt
    output logic             irq_o,
    // open-drain wire pin
    input  wire logic        wire_pin_i,
    output logic             wire_pin_o,
    output logic             wire_pin_oe_o,
    // search mode to the transfer engine
    output logic             search_assist_o
);
    owm_pkg::owm_state_s st;
    owm_pkg::owm_state_s next_st;
    logic                tick;
    logic                line_s;
    logic                setup;
    logic                access;
    logic                wr;
    logic                rd;
    logic                mapped;
    logic                seq_done;
    logic [31:0]         rdata;

    // ==========================================================
    // submodules
    owm_tick_div u_div (
        .mclk_i    (mclk_i),
        .rstn_i    (rstn_i),
        .ce_i      (ce_i),
        .divisor_i (st.divisor),
        .tick_o    (tick)
    );

    owm_line_sync u_sync (
        .mclk_i  (mclk_i),
        .rstn_i  (rstn_i),
        .ce_i    (ce_i),
        .async_i (wire_pin_i),
        .sync_o  (line_s)
    );

    // ==========================================================
    // apb phase decode; the answer is registered, so one access cycle
    assign setup    = psel_i && !penable_i;
    assign access   = psel_i && penable_i && st.pready;
    assign wr       = access && pwrite_i && !st.pslverr;
    assign rd       = access && !pwrite_i && !st.pslverr;
    assign seq_done = (st.state == owm_pkg::ST_RECOVER) && tick && (st.tick_cnt == `RECOVER_US - 10'h001);

    // read mux, sampled during the setup cycle
    always_comb
    begin
        rdata  = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr_i)
            `ADDR_CFG:   rdata[`CFG_MANUAL_EN] = st.manual_en;
            `ADDR_DIV:   rdata[`DIV_MSB:0]     = st.divisor;
            `ADDR_CTRL:
            begin
                rdata[`CTRL_PRESENCE]  = st.presence;
                rdata[`CTRL_OD_REV]    = `OD_REV_VALUE;               // RULE9
                rdata[`CTRL_LINE]      = line_s;                      // RULE4
                rdata[`CTRL_PULL_LOW]  = st.manual_low;
                rdata[`CTRL_SEARCH]    = st.search_assist;
                rdata[`CTRL_RESET_REQ] = st.reset_req;                // RULE8
            end
            `ADDR_INTFL: rdata[`INT_RESET_DONE] = st.done_flag;
            `ADDR_INTEN: rdata[`INT_RESET_DONE] = st.done_mask;
            default:     mapped = 1'b0;
        endcase
    end

    // ==========================================================
    // next state of the whole block
    always_comb
    begin
        next_st = st;

        // bus answer
        next_st.pready  = setup;
        next_st.pslverr = setup && !mapped;
        next_st.prdata  = setup ? rdata : 32'h0000_0000;

        // register writes
        if (wr)
        begin
            case (paddr_i)
                `ADDR_CFG: next_st.manual_en = pwdata_i[`CFG_MANUAL_EN];
                `ADDR_DIV: next_st.divisor   = pwdata_i[`DIV_MSB:0];
                `ADDR_CTRL:
                begin
                    next_st.manual_low    = pwdata_i[`CTRL_PULL_LOW];
                    next_st.search_assist = pwdata_i[`CTRL_SEARCH];   // RULE6
                    // a zero write cannot abort a running sequence
                    if (pwdata_i[`CTRL_RESET_REQ])
                        next_st.reset_req = 1'b1;                     // RULE7
                end
                `ADDR_INTFL:
                    if (pwdata_i[`INT_RESET_DONE])
                        next_st.done_flag = 1'b0;                     // RULE11
                `ADDR_INTEN: next_st.done_mask = pwdata_i[`INT_RESET_DONE];
                default: ;
            endcase
        end

        // a read of the flag register clears it as well
        if (rd && paddr_i == `ADDR_INTFL)
            next_st.done_flag = 1'b0;

        // sequencer; a stopped tick freezes it mid-sequence
        case (st.state)
            owm_pkg::ST_IDLE:
            begin
                next_st.tick_cnt = 10'h000;
                if (st.reset_req)
                begin
                    next_st.state         = owm_pkg::ST_LOW;          // RULE7
                    next_st.presence_seen = 1'b0;
                end
            end
            owm_pkg::ST_LOW:
                if (tick)                                             // RULE1
                begin
                    if (st.tick_cnt == `RESET_LOW_US - 10'h001)
                    begin
                        next_st.tick_cnt = 10'h000;
                        next_st.state    = owm_pkg::ST_SAMPLE;
                    end
                    else
                        next_st.tick_cnt = st.tick_cnt + 10'h001;
                end
            owm_pkg::ST_SAMPLE:
                if (tick)
                begin
                    if (st.tick_cnt == `SAMPLE_US - 10'h001)
                    begin
                        next_st.tick_cnt      = 10'h000;
                        next_st.presence_seen = !line_s;              // RULE3
                        next_st.state         = owm_pkg::ST_RECOVER;
                    end
                    else
                        next_st.tick_cnt = st.tick_cnt + 10'h001;
                end
            owm_pkg::ST_RECOVER:
                if (seq_done)
                begin
                    next_st.state     = owm_pkg::ST_IDLE;
                    next_st.reset_req = 1'b0;                         // RULE8
                    next_st.presence  = st.presence_seen;             // RULE3 RULE12
                    next_st.done_flag = 1'b1;                         // RULE11
                end
                else if (tick)
                    next_st.tick_cnt = st.tick_cnt + 10'h001;
            default:
                next_st.state = owm_pkg::ST_IDLE;
        endcase

        // pin: manual control overrides the sequencer
        if (next_st.manual_en)
            next_st.line_oe = next_st.manual_low;                     // RULE5 RULE10
        else
            next_st.line_oe = (next_st.state == owm_pkg::ST_LOW);

        next_st.irq = next_st.done_flag && next_st.done_mask;
    end

    // ==========================================================
    // the one state register; enable low freezes everything
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st         <= '0;
            st.state   <= owm_pkg::ST_IDLE;
            st.divisor <= `DIV_RESET;
        end
        else if (ce_i)
            st <= next_st;
    end

    // outputs straight from flops; the pin only ever pulls low
    assign prdata_o        = st.prdata;
    assign pready_o        = st.pready;
    assign pslverr_o       = st.pslverr;
    assign irq_o           = st.irq;
    assign wire_pin_o      = 1'b0;
    assign wire_pin_oe_o   = st.line_oe;
    assign search_assist_o = st.search_assist;

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_finish;
        ce_i && seq_done;
    endsequence

    sequence s_start;
        ce_i && st.state == owm_pkg::ST_IDLE && st.reset_req && !st.manual_en;
    endsequence

    property p_no_tick;
        (st.divisor == 8'h00)[*2] |-> !tick;
    endproperty
    a_no_tick : assert property (p_no_tick) else $error("tick with zero divisor"); // RULE1

    property p_presence;
        s_finish |=> st.presence == $past(st.presence_seen);
    endproperty
    a_presence : assert property (p_presence) else $error("presence not latched"); // RULE3

    property p_line_read;
        (ce_i && setup && paddr_i == `ADDR_CTRL) |=> prdata_o[`CTRL_LINE] == $past(line_s);
    endproperty
    a_line_read : assert property (p_line_read) else $error("line level wrong"); // RULE4

    property p_manual;
        (ce_i && next_st.manual_en) |=> wire_pin_oe_o == $past(next_st.manual_low);
    endproperty
    a_manual : assert property (p_manual) else $error("manual pin wrong"); // RULE5

    property p_search;
        (ce_i && wr && paddr_i == `ADDR_CTRL) |=> search_assist_o == $past(pwdata_i[`CTRL_SEARCH]);
    endproperty
    a_search : assert property (p_search) else $error("search mode not taken"); // RULE6

    property p_start;
        s_start |=> st.state == owm_pkg::ST_LOW ##1 (!ce_i || wire_pin_oe_o);
    endproperty
    a_start : assert property (p_start) else $error("reset did not start"); // RULE7

    property p_clear_req;
        s_finish |=> !st.reset_req && st.state == owm_pkg::ST_IDLE;
    endproperty
    a_clear_req : assert property (p_clear_req) else $error("request not cleared"); // RULE8

    // only the control word carries the revision bit; the divisor may set bit 4
    property p_od_rev;
        (ce_i && setup && paddr_i == `ADDR_CTRL) |=> !prdata_o[`CTRL_OD_REV];
    endproperty
    a_od_rev : assert property (p_od_rev) else $error("overdrive bit set"); // RULE9

    property p_auto_pin;
        (ce_i && !next_st.manual_en && next_st.state == owm_pkg::ST_IDLE) |=> !wire_pin_oe_o;
    endproperty
    a_auto_pin : assert property (p_auto_pin) else $error("pin driven while idle"); // RULE10

    property p_done_flag;
        s_finish |=> st.done_flag;
    endproperty
    a_done_flag : assert property (p_done_flag) else $error("done flag not set"); // RULE11

    property p_hold;
        st.state != owm_pkg::ST_RECOVER |=> $stable(st.presence);
    endproperty
    a_hold : assert property (p_hold) else $error("presence changed"); // RULE12

    // request bit stands for the whole sequence, or software sees a false finish
    property p_req_held;
        st.state != owm_pkg::ST_IDLE |-> st.reset_req;
    endproperty
    a_req_held : assert property (p_req_held) else $error("request dropped early"); // RULE8

    // write-one clear, unless a completion lands in the same cycle
    property p_flag_clear;
        (ce_i && wr && paddr_i == `ADDR_INTFL && pwdata_i[`INT_RESET_DONE] && !seq_done) |=> !st.done_flag;
    endproperty
    a_flag_clear : assert property (p_flag_clear) else $error("flag not cleared"); // RULE11

    // interrupt level follows flag and mask with no extra delay
    property p_irq_level;
        irq_o == (st.done_flag && st.done_mask);
    endproperty
    a_irq_level : assert property (p_irq_level) else $error("irq level wrong"); // RULE11
endmodule : owm_master_ctrl

// ==== include/owm_defines.svh ====
/*
 * register map, field positions and sequence timings of the single-wire bus master.
 * assumes: included by its bare name; one tick of the timing clock is about 1 us.
 */
`ifndef OWM_DEFINES_SVH
`define OWM_DEFINES_SVH

// ==========================================================
// register byte addresses
`define ADDR_CFG        8'h00
`define ADDR_DIV        8'h04
`define ADDR_CTRL       8'h08
`define ADDR_INTFL      8'h10
`define ADDR_INTEN      8'h14

// ==========================================================
// field positions
`define DIV_MSB         7
`define CFG_MANUAL_EN   2
`define CTRL_PRESENCE   7
`define CTRL_OD_REV     4
`define CTRL_LINE       3
`define CTRL_PULL_LOW   2
`define CTRL_SEARCH     1
`define CTRL_RESET_REQ  0
`define INT_RESET_DONE  0

// ==========================================================
// reset values
`define DIV_RESET       8'h00
`define OD_REV_VALUE    1'b0

// ==========================================================
// reset sequence, in timing ticks (1 tick = 1 us)
`define RESET_LOW_US    10'h1e0
`define SAMPLE_US       10'h046
`define RECOVER_US      10'h19a

`endif

// ==== include/owm_pkg.sv ====
/*
 * types of the single-wire bus master: sequencer states and state records.
 * assumes: nothing; every use is written owm_pkg::name.
 */
package owm_pkg;

    // ==========================================================
    // reset and presence sequencer
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_LOW     = 2'b01,
        ST_SAMPLE  = 2'b10,
        ST_RECOVER = 2'b11
    } seq_state_e;

    // ==========================================================
    // state records
    typedef struct packed {
        seq_state_e  state;
        logic [9:0]  tick_cnt;
        logic [7:0]  divisor;
        logic        manual_en;
        logic        manual_low;
        logic        search_assist;
        logic        reset_req;
        logic        presence;
        logic        presence_seen;
        logic        done_flag;
        logic        done_mask;
        logic        line_oe;
        logic        irq;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } owm_state_s;

    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } div_state_s;

    typedef struct packed {
        logic meta;
        logic stable;
    } sync_state_s;

endpackage : owm_pkg

// ==== hw/owm_line_sync.sv ====
/*
 * two-flop synchroniser for the wire pin level.
 * assumes: asynchronous input; enable freezes both flops.
 */
`timescale 1ns/1ps
module owm_line_sync (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic rstn_i,
    input  wire logic ce_i,
    // level in and out
    input  wire logic async_i,
    output logic      sync_o
);
    owm_pkg::sync_state_s st;
    owm_pkg::sync_state_s next_st;

    // ==========================================================
    // meta flop feeds only the stable flop
    always_comb
    begin
        next_st.meta   = async_i;
        next_st.stable = st.meta;
    end

    // reset high: an idle open-drain wire is pulled up
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            st <= '{meta: 1'b1, stable: 1'b1};
        else if (ce_i)
            st <= next_st;
    end

    assign sync_o = st.stable;
endmodule : owm_line_sync

// ==== hw/owm_tick_div.sv ====
/*
 * timing clock divider: one-cycle tick every divisor cycles of mclk.
 * assumes: divisor from a register on the same clock.
 */
`timescale 1ns/1ps
`include "owm_defines.svh"
module owm_tick_div (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    input  wire logic       ce_i,
    // divisor and tick
    input  wire logic [7:0] divisor_i,
    output logic            tick_o
);
    owm_pkg::div_state_s st;
    owm_pkg::div_state_s next_st;

    // ==========================================================
    // zero divisor parks the counter, no ticks at all
    always_comb
    begin
        next_st = st;
        next_st.tick = 1'b0;
        if (divisor_i == `DIV_RESET)                                  // RULE1
            next_st.cnt = 8'h00;
        else if (st.cnt >= divisor_i - 8'h01)                         // RULE2
        begin
            next_st.cnt  = 8'h00;
            next_st.tick = 1'b1;
        end
        else
            next_st.cnt = st.cnt + 8'h01;
    end

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            st <= '0;
        else if (ce_i)
            st <= next_st;
    end

    assign tick_o = st.tick;

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    property p_div_gap;
        (ce_i && tick_o && divisor_i > 8'h01) |=> !tick_o;
    endproperty
    a_div_gap : assert property (p_div_gap) else $error("tick repeated too soon"); // RULE2
endmodule : owm_tick_div

// ==== testbench/owm_slave_model.sv ====
/*
 * behavioural slave population on the open-drain wire: answers a bus reset
 * with a presence pulse, promptly or slowly, or stays silent.
 * assumes: external pull-up; wire level resolved by the bench; unit_i is
 * mclk cycles per timing tick and is stable during a sequence.
 */
`timescale 1ns/1ps
module owm_slave_model (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    // behaviour: 0 absent, 1 prompt, 2 slow
    input  wire logic [1:0] mode_i,
    input  wire logic [7:0] unit_i,
    // wire
    input  wire logic       wire_i,
    output logic            pull_o
);
    int   low_cnt;
    int   wait_cnt;
    logic armed;
    int   dly;

    // ==========================================================
    // reset pulse detection and presence answer
    assign dly = (mode_i == 2'd2) ? 60 * unit_i : 20 * unit_i;

    // own pull is not counted, so the answer never re-arms itself
    always @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            low_cnt  <= 0;
            wait_cnt <= 0;
            armed    <= 1'b0;
            pull_o   <= 1'b0;
        end
        else
        begin
            low_cnt <= (!wire_i && !pull_o) ? low_cnt + 1 : 0;
            if (low_cnt >= 240 * unit_i && wire_i)
            begin
                armed    <= 1'b1;
                wait_cnt <= 0;
            end
            else if (armed)
            begin
                wait_cnt <= wait_cnt + 1;
                if (wait_cnt == dly)
                    pull_o <= (mode_i != 2'd0);
                if (wait_cnt == dly + 120 * unit_i)
                begin
                    pull_o <= 1'b0;
                    armed  <= 1'b0;
                end
            end
        end
    end
endmodule : owm_slave_model

// ==== testbench/test_one_wire_master_clock_control.sv ====
/*
 * self-checking bench of the single-wire master control block.
 * assumes: apb master in this module; expected read results queued by the
 * driver and compared by a separate monitor process.
 */
`timescale 1ns/1ps
`include "owm_defines.svh"
module test_one_wire_master_clock_control;
    // ==========================================================
    // signals
    logic        mclk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic        pready, pslverr, irq, pin_o, pin_oe, search, slave_pull;
    logic [1:0]  slave_mode = 2'd0;
    logic [7:0]  unit = 8'h01;
    typedef struct packed { logic [31:0] data; logic [31:0] mask; logic err; } note_s;
    note_s       notes[$];
    note_s       mon_note;
    int          fails = 0, n_tests = 0, seed = 79664;
    wire         wire_level = ~((pin_oe & ~pin_o) | slave_pull);

    // 200 MHz clock
    always #2.5 mclk_i = ~mclk_i;

    owm_master_ctrl u_owm_master_ctrl (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(1'b1),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .irq_o(irq), .wire_pin_i(wire_level), .wire_pin_o(pin_o), .wire_pin_oe_o(pin_oe),
        .search_assist_o(search));

    owm_slave_model u_owm_slave_model (.mclk_i(mclk_i), .rstn_i(rstn_i), .mode_i(slave_mode),
        .unit_i(unit), .wire_i(wire_level), .pull_o(slave_pull));

    // ==========================================================
    // reporting
    task finish_test;
        $display("counts: %0d compared, %0d mismatched", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task timeout(input string what);
        fails++;
        $display("mismatch at %0t: %s timed out", $time, what);
        finish_test();
    endtask : timeout

    // ==========================================================
    // apb master: request held until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
             input logic [31:0] exp, input logic [31:0] msk, input logic err);
        int i;
        notes.push_back('{exp, msk, err});
        @(posedge mclk_i);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge mclk_i);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge mclk_i);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
            timeout("apb answer");
        d = prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, 32'h0, 32'h0, 1'b0);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
        apb(1'b0, a, 32'h0, exp, msk, 1'b0);
    endtask : rd

    // polls the request bit; a hang counts as a mismatch
    task poll_done;
        int i;
        for (i = 0; i < 1000; i++)
        begin
            rd(`ADDR_CTRL, 32'h0, 32'h0);
            if (d[`CTRL_RESET_REQ] === 1'b0)
                break;
        end
        if (i == 1000)
            timeout("reset sequence");
    endtask : poll_done

    // one reset and presence sequence with a random divisor
    task run_reset(input logic [1:0] mode);
        logic [7:0] div;
        int         cnt;
        div = 8'd1 + 8'($unsigned($random(seed)) % 3);
        slave_mode <= mode;
        unit       <= div;
        wr(`ADDR_INTEN, {31'h0, mode == 2'd1});
        wr(`ADDR_DIV, ($random(seed) & 32'hffff_ff00) | {24'h0, div});
        rd(`ADDR_DIV, {24'h0, div}, 32'hffff_ffff);
        wr(`ADDR_CTRL, 32'h1);
        for (cnt = 0; cnt < 50 && pin_oe !== 1'b1; cnt++)
            @(posedge mclk_i);
        check({31'h0, pin_oe}, 32'h1, "reset pulse start");
        cnt = 0;
        while (pin_oe === 1'b1 && cnt < 3000)
        begin
            @(posedge mclk_i);
            cnt++;
        end
        check({31'h0, cnt >= 479 * div && cnt <= 481 * div}, 32'h1, "pulse length");
        poll_done();
        rd(`ADDR_CTRL, {24'h0, mode != 2'd0, 7'h0}, 32'h81);
        check({31'h0, irq}, {31'h0, mode == 2'd1}, "irq after done");
        if (mode == 2'd1)
        begin
            rd(`ADDR_INTFL, 32'h1, 32'h1);
            repeat (2) @(posedge mclk_i);
            check({31'h0, irq}, 32'h0, "irq after read");
        end
        else
        begin
            wr(`ADDR_INTFL, 32'h1);
            rd(`ADDR_INTFL, 32'h0, 32'hffff_ffff);
        end
        $display("test reset mode %0d done", mode);
    endtask : run_reset

    // ==========================================================
    // monitor: oldest note against each finished transfer
    always @(posedge mclk_i)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            n_tests++;
            if (notes.size() == 0)
            begin
                fails++;
                $display("mismatch at %0t: unexpected transfer", $time);
            end
            else
            begin
                mon_note = notes.pop_front();
                if ((prdata & mon_note.mask) !== (mon_note.data & mon_note.mask) || pslverr !== mon_note.err)
                begin
                    fails++;
                    $display("mismatch at %0t: read %h err %b exp %h err %b", $time, prdata, pslverr,
                             mon_note.data, mon_note.err);
                end
            end
        end
    end

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (12) @(posedge mclk_i);
        rstn_i <= 1'b1;
        rd(`ADDR_DIV, 32'h0, 32'hffff_ffff);
        rd(`ADDR_CTRL, 32'h8, 32'hffff_ffff);
        apb(1'b0, 8'h20, 32'h0, 32'h0, 32'hffff_ffff, 1'b1);
        $display("test reset values done");
        // divisor zero: the request must stay pending
        wr(`ADDR_CTRL, 32'h1);
        repeat (1000) @(posedge mclk_i);
        rd(`ADDR_CTRL, 32'h1, 32'h1);
        rd(`ADDR_INTFL, 32'h0, 32'h1);
        wr(`ADDR_DIV, 32'h1);
        poll_done();
        rd(`ADDR_INTFL, 32'h1, 32'h1);
        $display("test divisor zero done");
        run_reset(2'd0);
        run_reset(2'd2);
        run_reset(2'd1);
        // manual line control, presence must survive
        wr(`ADDR_CFG, 32'h4);
        wr(`ADDR_CTRL, 32'h4);
        repeat (4) @(posedge mclk_i);
        check({31'h0, pin_oe}, 32'h1, "manual low");
        check({31'h0, pin_o}, 32'h0, "pin drives low only");
        rd(`ADDR_CTRL, 32'h84, 32'h8c);
        wr(`ADDR_CTRL, 32'h0);
        repeat (4) @(posedge mclk_i);
        check({31'h0, pin_oe}, 32'h0, "manual release");
        rd(`ADDR_CTRL, 32'h88, 32'h8c);
        wr(`ADDR_CFG, 32'h0);
        wr(`ADDR_CTRL, 32'h4);
        repeat (4) @(posedge mclk_i);
        check({31'h0, pin_oe}, 32'h0, "manual disabled");
        rd(`ADDR_CTRL, 32'h8c, 32'h8c);
        $display("test manual line done");
        wr(`ADDR_CTRL, 32'h2);
        @(posedge mclk_i);
        check({31'h0, search}, 32'h1, "search on");
        rd(`ADDR_CTRL, 32'h2, 32'h2);
        wr(`ADDR_CTRL, 32'h0);
        @(posedge mclk_i);
        check({31'h0, search}, 32'h0, "search off");
        $display("test search assist done");
        repeat (4) @(posedge mclk_i);
        finish_test();
    end
endmodule : test_one_wire_master_clock_control
